// ===== src/eeprom_pkg.sv
// Shared constants, states and carriers of the two-wire memory slave
package eeprom_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 128;
  localparam int PAGE_BYTES = 4;
  localparam int PAGE_IDX_W = 2;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;
  localparam int RW_BIT = 0;
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;

  // Self-timed write cycle, typical figure
  localparam int CLK_HZ = 20_000_000;
  localparam int WRITE_TIME_US = 5000;
  localparam int WRITE_CYCLES_DEF = WRITE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int BUSY_CNT_W = 17;

  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WR_DATA  = 3'b011,
    ST_WR_ACK   = 3'b100,
    ST_RD_DATA  = 3'b101,
    ST_RD_ACK   = 3'b110,
    ST_WAIT     = 3'b111
  } slave_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } lines_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mem_wr_t;

endpackage

// ===== src/line_sync.sv
// Two-flop synchroniser for the bus clock and data lines
`timescale 1ns/10ps
module line_sync
  import eeprom_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_in,
  output lines_t lines
);

  lines_t meta_reg;
  lines_t sync_reg;

  // Idle bus level is high, so reset to high to avoid a false start
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= '{scl: scl, sda: sda_in};
      sync_reg <= meta_reg;
    end
  end

  assign lines = sync_reg;

endmodule

// ===== src/mem_128x8.sv
// Byte array with one write port and a registered read port
`timescale 1ns/10ps
module mem_128x8
  import eeprom_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input mem_wr_t wr,
  input wire logic [ADDR_W-1:0] raddr,
  output logic [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] cells [MEM_DEPTH];

  always_ff @(posedge mclk) begin
    if (wr.we) begin
      cells[wr.addr] <= wr.data;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata <= DATA_RST;
    end else begin
      rdata <= cells[raddr];
    end
  end

endmodule

// ===== src/two_wire_eeprom_slave.sv
// Two-wire bus slave of a 128-byte memory with page write and self-timed write cycle
`timescale 1ns/10ps
module two_wire_eeprom_slave
  import eeprom_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic busy
);

  localparam logic [BUSY_CNT_W-1:0] BUSY_LAST = BUSY_CNT_W'(WRITE_CYCLES - 1);
  localparam logic [BUSY_CNT_W-1:0] COMMIT_END = BUSY_CNT_W'(PAGE_BYTES);

  // Every check in this module runs on the system clock
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  function automatic logic [ADDR_W-1:0] page_step(input logic [ADDR_W-1:0] a);
    page_step = {a[ADDR_W-1:PAGE_IDX_W], a[PAGE_IDX_W-1:0] + 2'h1};
  endfunction

  function automatic logic [ADDR_W-1:0] linear_step(input logic [ADDR_W-1:0] a);
    linear_step = a + 7'h01;
  endfunction

  lines_t lines;
  lines_t prev_reg;
  slave_state_t state_reg;
  logic [BIT_CNT_W-1:0] bit_cnt_reg;
  logic [DATA_W-1:0] rx_reg;
  logic [DATA_W-1:0] tx_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic ack_high_reg;
  logic oe_n_reg;
  logic busy_reg;
  logic [BUSY_CNT_W-1:0] busy_cnt_reg;
  logic [ADDR_W-PAGE_IDX_W-1:0] page_reg;
  logic [DATA_W-1:0] page_buf_reg [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_vld_reg;
  logic [DATA_W-1:0] rdata;
  mem_wr_t mem_wr;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_in;
  logic wr_byte_done;
  logic launch;
  logic [PAGE_IDX_W-1:0] commit_idx;

  // Pins lag two clocks; half periods of four clocks are long enough
  line_sync u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .scl(scl),
    .sda_in(sda_in),
    .lines(lines)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prev_reg <= '1;
    end else begin
      prev_reg <= lines;
    end
  end

  // Edges from synchronised levels only
  assign scl_rise = lines.scl && !prev_reg.scl;
  assign scl_fall = !lines.scl && prev_reg.scl;
  assign start_det = lines.scl && prev_reg.scl && prev_reg.sda && !lines.sda;
  assign stop_det = lines.scl && prev_reg.scl && !prev_reg.sda && lines.sda;
  assign byte_in = bit_cnt_reg == BITS_PER_BYTE;
  assign wr_byte_done = state_reg == ST_WR_DATA && scl_fall && byte_in;
  // Stop closes a write; a stop before any full byte writes nothing
  assign launch = stop_det && !busy_reg && page_vld_reg != '0
    && (state_reg == ST_WR_DATA || state_reg == ST_WR_ACK);

  // Main protocol engine; held idle for the whole internal write
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= '0;
      rx_reg <= DATA_RST;
      tx_reg <= DATA_RST;
      addr_reg <= ADDR_RST;
      ack_high_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else if (busy_reg) begin
      state_reg <= ST_IDLE;
      oe_n_reg <= 1'b1;
      bit_cnt_reg <= '0;
    end else if (start_det) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= '0;
      oe_n_reg <= 1'b1;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      oe_n_reg <= 1'b1;
    end else begin
      case (state_reg)
        ST_IDLE, ST_WAIT: begin
          oe_n_reg <= 1'b1;
        end
        ST_ADDR, ST_WR_DATA: begin
          if (scl_rise && !byte_in) begin
            rx_reg <= {rx_reg[DATA_W-2:0], lines.sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && byte_in) begin
            oe_n_reg <= 1'b0;
            ack_high_reg <= 1'b0;
            if (state_reg == ST_ADDR) begin
              addr_reg <= rx_reg[ADDR_MSB:ADDR_LSB];
              state_reg <= ST_ADDR_ACK;
            end else begin
              addr_reg <= page_step(addr_reg);
              state_reg <= ST_WR_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_rise) begin
            ack_high_reg <= 1'b1;
          end else if (scl_fall && ack_high_reg) begin
            bit_cnt_reg <= '0;
            if (rx_reg[RW_BIT]) begin
              state_reg <= ST_RD_DATA;
              oe_n_reg <= rdata[DATA_W-1];
              tx_reg <= {rdata[DATA_W-2:0], 1'b0};
            end else begin
              state_reg <= ST_WR_DATA;
              oe_n_reg <= 1'b1;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_rise) begin
            ack_high_reg <= 1'b1;
          end else if (scl_fall && ack_high_reg) begin
            oe_n_reg <= 1'b1;
            bit_cnt_reg <= '0;
            state_reg <= ST_WR_DATA;
          end
        end
        ST_RD_DATA: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (byte_in) begin
              oe_n_reg <= 1'b1;
              ack_high_reg <= 1'b0;
              state_reg <= ST_RD_ACK;
            end else begin
              oe_n_reg <= tx_reg[DATA_W-1];
              tx_reg <= {tx_reg[DATA_W-2:0], 1'b0};
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            if (!lines.sda) begin
              ack_high_reg <= 1'b1;
              addr_reg <= linear_step(addr_reg);
            end else begin
              state_reg <= ST_WAIT;
            end
          end else if (scl_fall && ack_high_reg) begin
            // Read data had several cycles to follow the new address
            bit_cnt_reg <= '0;
            state_reg <= ST_RD_DATA;
            oe_n_reg <= rdata[DATA_W-1];
            tx_reg <= {rdata[DATA_W-2:0], 1'b0};
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          oe_n_reg <= 1'b1;
        end
      endcase
    end
  end

  // Page buffer; bytes reach the array only once the stop is seen
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      page_vld_reg <= '0;
      page_reg <= '0;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        page_buf_reg[i] <= DATA_RST;
      end
    end else if (launch) begin
      page_reg <= addr_reg[ADDR_W-1:PAGE_IDX_W];
    end else if (start_det && !busy_reg) begin
      page_vld_reg <= '0;
    end else if (wr_byte_done) begin
      page_buf_reg[addr_reg[PAGE_IDX_W-1:0]] <= rx_reg;
      page_vld_reg[addr_reg[PAGE_IDX_W-1:0]] <= 1'b1;
    end
  end

  // Self-timed write cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
      busy_cnt_reg <= '0;
    end else if (launch) begin
      busy_reg <= 1'b1;
      busy_cnt_reg <= '0;
    end else if (busy_reg) begin
      if (busy_cnt_reg == BUSY_LAST) begin
        busy_reg <= 1'b0;
      end else begin
        busy_cnt_reg <= busy_cnt_reg + 17'h00001;
      end
    end
  end

  // First four busy cycles copy the page buffer into the array
  assign commit_idx = busy_cnt_reg[PAGE_IDX_W-1:0];
  assign mem_wr.we = busy_reg && busy_cnt_reg < COMMIT_END && page_vld_reg[commit_idx];
  assign mem_wr.addr = {page_reg, commit_idx};
  assign mem_wr.data = page_buf_reg[commit_idx];

  // Read data follows the address a clock later, long before it is shifted out
  mem_128x8 u_mem (
    .mclk(mclk),
    .nrst(nrst),
    .wr(mem_wr),
    .raddr(addr_reg),
    .rdata(rdata)
  );

  // Open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe_n = oe_n_reg;
  assign busy = busy_reg;

  logic scl_q_reg;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      scl_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= lines.scl;
    end
  end

  // Length of the current busy spell, apart from the write counter
  logic [BUSY_CNT_W-1:0] busy_run_reg;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy_run_reg <= '0;
    end else if (busy_reg) begin
      busy_run_reg <= busy_run_reg + 17'h00001;
    end else begin
      busy_run_reg <= '0;
    end
  end

  sda_change_a: assert property ($changed(oe_n_reg) && !$past(busy_reg) |-> !scl_q_reg)
    else $error("data line driven change while clock high");
  start_addr_a: assert property (start_det && !busy_reg |=> state_reg == ST_ADDR && bit_cnt_reg == 4'h0)
    else $error("start did not open address phase");
  stop_idle_a: assert property (stop_det && !busy_reg |=> state_reg == ST_IDLE && oe_n_reg)
    else $error("stop did not return to idle");
  addr_ack_a: assert property (state_reg == ST_ADDR && scl_fall && byte_in && !start_det && !stop_det
    |=> !oe_n_reg && state_reg == ST_ADDR_ACK && addr_reg == $past(rx_reg[7:1]))
    else $error("address byte not acknowledged");
  busy_quiet_a: assert property (busy_reg |=> oe_n_reg && state_reg == ST_IDLE)
    else $error("response given during internal write");
  poll_nack_a: assert property (busy_reg && start_det |=> state_reg == ST_IDLE [*2])
    else $error("polling answered while busy");
  busy_len_a: assert property ($rose(busy_reg) |-> busy_cnt_reg == 17'h0 ##1 busy_reg [*3])
    else $error("internal write ended early");
  busy_end_a: assert property (busy_reg && busy_cnt_reg == BUSY_LAST |=> !busy_reg)
    else $error("internal write overran its count");
  page_wrap_a: assert property (wr_byte_done && !start_det && !stop_det && !busy_reg
    |=> addr_reg[6:2] == $past(addr_reg[6:2]) && addr_reg[1:0] == $past(addr_reg[1:0]) + 2'h1)
    else $error("page address advanced outside low bits");
  seq_inc_a: assert property (state_reg == ST_RD_ACK && scl_rise && !lines.sda && !busy_reg
    && !start_det && !stop_det |=> addr_reg == $past(addr_reg) + 7'h01)
    else $error("read address did not advance");
  nack_stop_a: assert property (state_reg == ST_RD_ACK && scl_rise && lines.sda && !busy_reg
    && !start_det && !stop_det |=> state_reg == ST_WAIT && oe_n_reg)
    else $error("read continued after missing acknowledge");
  tx_bit_a: assert property (state_reg == ST_RD_DATA && scl_fall && !byte_in && !start_det && !stop_det
    && !busy_reg |=> oe_n_reg == $past(tx_reg[7]))
    else $error("read bit not most significant first");

  // Write length, acknowledges, release and page launch
  busy_span_a: assert property ($fell(busy_reg) |-> busy_run_reg == BUSY_LAST + 17'h00001)
    else $error("internal write length wrong");
  wr_ack_a: assert property (state_reg == ST_WR_DATA && scl_fall && byte_in && !busy_reg
    |=> !oe_n_reg && state_reg == ST_WR_ACK)
    else $error("data byte not acknowledged");
  rd_release_a: assert property (state_reg == ST_RD_DATA && scl_fall && byte_in && !busy_reg
    |=> oe_n_reg && state_reg == ST_RD_ACK)
    else $error("data line not released after read byte");
  ack_hold_a: assert property ((state_reg == ST_ADDR_ACK || state_reg == ST_WR_ACK) && !scl_fall
    && !start_det && !stop_det && !busy_reg |=> !oe_n_reg)
    else $error("acknowledge dropped before clock fall");
  idle_quiet_a: assert property (state_reg == ST_IDLE |-> oe_n_reg)
    else $error("data line driven while idle");
  no_launch_a: assert property (stop_det && page_vld_reg == 4'h0 && !busy_reg |=> !busy_reg)
    else $error("empty write launched a write cycle");
  read_load_a: assert property (state_reg == ST_ADDR_ACK && scl_fall && ack_high_reg && rx_reg[RW_BIT]
    && !busy_reg |=> state_reg == ST_RD_DATA && oe_n_reg == $past(rdata[7]))
    else $error("read did not start with addressed byte");
  launch_page_a: assert property (launch |=> busy_reg && busy_cnt_reg == 17'h0
    && page_reg == $past(addr_reg[6:2]))
    else $error("write cycle launched with wrong page");

  byte_write_c: cover property (launch ##1 busy_reg);
  page_full_c: cover property (launch && page_vld_reg == 4'hf);
  seq_read_c: cover property (state_reg == ST_RD_ACK && ack_high_reg && scl_fall);
  poll_c: cover property (busy_reg && start_det);
  page_wrap_c: cover property (wr_byte_done && page_vld_reg == 4'hf);

endmodule

// ===== test/bus_master_model.sv
// Bus master model that clocks the two-wire line and pulls its data low
`timescale 1ns/10ps
module bus_master_model (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic pull_low
);
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end

  // Steps of one system clock just after the edge; 4 steps make a 200 ns half period
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Data moves mid low phase, sampled mid high phase, well clear of the slave's drive delay
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    tick(2);
    pull_low = !b;
    tick(2);
    scl = 1'b1;
    tick(2);
    r = sda;
    tick(2);
  endtask

  task automatic start();
    pull_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(2);
    pull_low = 1'b1;
    tick(2);
  endtask

  // Entered with the clock high after a bit; the slave lets go in the low phase
  task automatic stop();
    scl = 1'b0;
    tick(2);
    pull_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(2);
    pull_low = 1'b0;
    tick(4);
  endtask

  task automatic byte_tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask

  task automatic byte_rx(input logic give_ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(!give_ack, r);
  endtask
endmodule

// ===== test/tb_two_wire_eeprom_slave.sv
// Self-checking bench of the two-wire memory slave
`timescale 1ns/10ps
module tb_two_wire_eeprom_slave;
  import eeprom_pkg::*;
  // Short write cycle, still long enough for one polling address byte
  localparam int WC = 400;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic scl;
  logic pull_low;
  logic sda_out;
  logic sda_oe_n;
  logic busy;
  logic sda_line;
  int mismatches = 0;
  int samples_checked = 0;
  int busy_len = 0;

  // Pull-up wins unless either party pulls low
  assign sda_line = ((sda_oe_n === 1'b0) ? sda_out : 1'b1) & !pull_low;

  two_wire_eeprom_slave #(.WRITE_CYCLES(WC)) i_dut (.mclk(mclk), .nrst(nrst), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .busy(busy));
  bus_master_model i_master (.mclk(mclk), .sda(sda_line), .scl(scl), .pull_low(pull_low));

  initial begin
    forever #25 mclk = ~mclk;
  end

  always @(negedge mclk) begin
    if (busy === 1'b1) begin
      busy_len++;
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic no_start();
    logic ack;
    i_master.byte_tx(8'h2a, ack);
    check({15'h0, ack}, 16'h0000);
    i_master.stop();
  endtask

  task automatic wr_seq(input logic [6:0] addr, input logic [4:0][7:0] data, input int n, input logic poll);
    logic ack;
    int i;
    i_master.start();
    i_master.byte_tx({addr, 1'b0}, ack);
    check({15'h0, ack}, 16'h0001);
    for (i = 0; i < n; i++) begin
      i_master.byte_tx(data[i], ack);
      check({15'h0, ack}, 16'h0001);
    end
    busy_len = 0;
    i_master.stop();
    check({15'h0, busy}, 16'h0001);
    if (poll) begin
      i_master.start();
      i_master.byte_tx({addr, 1'b0}, ack);
      check({15'h0, ack}, 16'h0000);
      i_master.stop();
    end
    for (i = 0; i < WC + 40 && busy !== 1'b0; i++) begin
      i_master.tick(1);
    end
    check(16'(busy_len), 16'(WC));
    if (poll) begin
      i_master.start();
      i_master.byte_tx({addr, 1'b0}, ack);
      check({15'h0, ack}, 16'h0001);
      i_master.stop();
      check({15'h0, busy}, 16'h0000);
    end
  endtask

  // One extra byte is clocked after the final refusal to see the slave stay off the line
  task automatic rd_seq(input logic [6:0] addr, input logic [4:0][7:0] exp, input int n);
    logic ack;
    logic [7:0] d;
    i_master.start();
    i_master.byte_tx({addr, 1'b1}, ack);
    check({15'h0, ack}, 16'h0001);
    check({15'h0, sda_out}, 16'h0000);
    for (int k = 0; k < n; k++) begin
      i_master.byte_rx(k < n - 1, d);
      check({8'h00, d}, {8'h00, exp[k]});
    end
    i_master.byte_rx(1'b0, d);
    check({8'h00, d}, 16'h00ff);
    i_master.stop();
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    #1;
    nrst = 1'b1;
    i_master.tick(4);
    no_start();
    wr_seq(7'h15, 40'h00000000a5, 1, 1'b1);
    rd_seq(7'h15, 40'h00000000a5, 1);
    no_start();
    wr_seq(7'h22, 40'h5544332211, 5, 1'b0);
    rd_seq(7'h20, 40'h0022554433, 4);
    wr_seq(7'h7f, 40'h000000009c, 1, 1'b0);
    wr_seq(7'h00, 40'h00000000c3, 1, 1'b0);
    rd_seq(7'h7f, 40'h000000c39c, 2);
    close_out();
  end

  // Whole run needs well under a millisecond
  initial begin
    #2000000;
    mismatches++;
    close_out();
  end
endmodule
